// File: design/nme_clk_div.sv
`timescale 1ns/1ps
`default_nettype none

module nme_clk_div
    import nme_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        src_level,
    input  wire logic        src_rise,
    input  wire nme_div_type div_sel,
    output logic             div_clk
);

    typedef struct packed {
        logic [1:0] cnt;
        logic       out;
    } nme_div_state_type;

    nme_div_state_type s_q;
    nme_div_state_type s_d;

    always_comb begin
        s_d = s_q;
        if (src_rise) begin
            s_d.cnt = s_q.cnt + 2'h1;
        end
        case (div_sel)
            NME_DIV_1: begin
                s_d.out = src_level;
            end
            NME_DIV_2: begin
                if (src_rise) begin
                    s_d.out = ~s_q.out;
                end
            end
            NME_DIV_4: begin
                if (src_rise && s_q.cnt[0]) begin
                    s_d.out = ~s_q.out;
                end
            end
            default: begin
                s_d.out = src_level;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign div_clk = s_q.out;

endmodule

`default_nettype wire

// File: design/nme_pkg.sv
package nme_pkg;

    // apb register byte offsets
    localparam logic [7:0] NME_OFS_CTRL   = 8'h00;
    localparam logic [7:0] NME_OFS_ADDR   = 8'h04;
    localparam logic [7:0] NME_OFS_STATUS = 8'h08;
    localparam logic [7:0] NME_OFS_STRAP  = 8'h0C;

    // external address pins run from bit 1 to bit 20 (half-word address)
    localparam int NME_ADDR_LSB = 1;
    localparam int NME_ADDR_MSB = 20;
    localparam int NME_ADDR_W   = NME_ADDR_MSB - NME_ADDR_LSB + 1;

    // strap positions on the external address pins
    localparam int NME_STRAP_ENDIAN   = 20;
    localparam int NME_STRAP_BOOT_LSB = 18;
    localparam int NME_STRAP_WIDE_LSB = 16;
    localparam int NME_STRAP_NARR_LSB = 14;
    localparam int NME_STRAP_EEPROM_AUTO_INIT_STRAP     = 13;
    localparam int NME_STRAP_CELL     = 11;

    // ctrl register fields
    localparam int NME_CTRL_DIV_LSB   = 0;
    localparam int NME_CTRL_MTYPE_LSB = 2;
    localparam int NME_CTRL_RENSEL    = 4;
    localparam int NME_CTRL_SPACE_LSB = 5;
    localparam int NME_CTRL_WRITE     = 7;
    localparam int NME_CTRL_START     = 8;

    // status register fields
    localparam int NME_STAT_BUSY      = 0;
    localparam int NME_STAT_DONE      = 1;
    localparam int NME_STAT_CLK_RSVD  = 2;

    // strap register fields
    localparam int NME_SR_ENDIAN      = 0;
    localparam int NME_SR_BOOT_LSB    = 1;
    localparam int NME_SR_NARR_LSB    = 3;
    localparam int NME_SR_WIDE_LSB    = 5;
    localparam int NME_SR_EEPROM_AUTO_INIT_STRAP        = 7;
    localparam int NME_SR_CELL        = 8;

    // processor clock derived sources: full periods in pclk cycles
    localparam int         NME_CPU_DIV4  = 4;
    localparam int         NME_CPU_DIV6  = 6;
    localparam logic [1:0] NME_HALF_DIV4 = 2'(NME_CPU_DIV4 / 2 - 1);
    localparam logic [1:0] NME_HALF_DIV6 = 2'(NME_CPU_DIV6 / 2 - 1);

    localparam logic [1:0] NME_SPACE_FIFO = 2'h3;

    typedef enum logic [1:0] {
        NME_CLK_EXT  = 2'h0,
        NME_CLK_DIV4 = 2'h1,
        NME_CLK_DIV6 = 2'h2,
        NME_CLK_RSVD = 2'h3
    } nme_clk_src_type;

    typedef enum logic [1:0] {
        NME_BOOT_NONE = 2'h0,
        NME_BOOT_HOST = 2'h1,
        NME_BOOT_ROM8 = 2'h2,
        NME_BOOT_RSVD = 2'h3
    } nme_boot_type;

    typedef enum logic [1:0] {
        NME_DIV_1 = 2'h0,
        NME_DIV_2 = 2'h1,
        NME_DIV_4 = 2'h2
    } nme_div_type;

    typedef enum logic [1:0] {
        NME_MEM_ASYNC = 2'h0,
        NME_MEM_SDRAM = 2'h1,
        NME_MEM_SYNC  = 2'h2
    } nme_mem_type;

    // gray coded along idle -> setup -> strobe -> hold
    typedef enum logic [1:0] {
        NME_ST_IDLE   = 2'b00,
        NME_ST_SETUP  = 2'b01,
        NME_ST_STROBE = 2'b11,
        NME_ST_HOLD   = 2'b10
    } nme_state_type;

    typedef struct packed {
        logic            little_endian;
        nme_boot_type    boot_mode;
        nme_clk_src_type narrow_clock_strap;
        nme_clk_src_type wide_clock_strap;
        logic            eeprom_auto_init_strap;
        logic            cell_port_enable_strap;
    } nme_strap_type;

    localparam nme_strap_type NME_STRAP_RESET = '{
        little_endian:          1'b1,
        boot_mode:              NME_BOOT_ROM8,
        narrow_clock_strap:     NME_CLK_EXT,
        wide_clock_strap:       NME_CLK_EXT,
        eeprom_auto_init_strap: 1'b0,
        cell_port_enable_strap: 1'b0
    };

    // active low memory strobes
    typedef struct packed {
        logic read_strobe_n;
        logic output_enable_n;
        logic write_strobe_n;
        logic fifo_oe_n;
    } nme_strobe_type;

    localparam nme_strobe_type NME_STROBE_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1};

endpackage

// File: design/nme_strap_pins.sv
// Behaviour
// - narrow clock source chosen from reset straps
// - narrow strap: ext, cpu/4, cpu/6, reserved
// - wide strap: ext, cpu/4, cpu/6, reserved
// - divided clock: selected clock /1, /2, /4
// - full-rate clock follows selected clock
// - read strobe pin shared by memory type
// - read_enable_select picks address strobe or read enable
// - output enable pin shared by memory type
// - write strobe pin shared by memory type
// - fifo output enable tied to space three
// - address pins carry half-word address
// - address pins are inputs during reset
// - endian strap: 0 big, 1 little
// - boot strap: none, host, rom8, reserved
// - eeprom strap enables auto-initialisation
// - cell-port strap swaps cell port and serial one
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none

module nme_strap_pins
    import nme_pkg::*;
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  ext_input_clock,
    input  wire logic                  async_ready_in,
    input  wire logic [NME_ADDR_W-1:0] external_address_bus_i,
    output logic [NME_ADDR_W-1:0]      external_address_bus_o,
    output logic [NME_ADDR_W-1:0]      external_address_bus_oe,
    output logic                       full_rate_output_clock,
    output logic                       divided_output_clock,
    output nme_strobe_type             strobe_pins,
    output nme_strap_type              straps,
    output logic                       serial_port_one_en,
    output logic                       cell_port_en,
    output logic                       eeprom_auto_init_en,
    output nme_clk_src_type            wide_clock_sel
);

    typedef struct packed {
        logic            captured;
        nme_strap_type   strap;
        logic            ext_s;
        logic [1:0]      cnt4;
        logic [1:0]      cnt6;
        logic            clk4;
        logic            clk6;
        logic            sel_clk;
        nme_div_type     div;
        nme_mem_type     mtype;
        logic            rensel;
        logic [1:0]      space;
        logic            wr;
        logic [19:0]     addr;
        nme_state_type   state;
        logic            done;
        nme_strobe_type  pins;
        logic [31:0]     rdata;
    } nme_state_all_type;

    nme_state_all_type s_q;
    nme_state_all_type s_d;

    logic       cur_clk;
    logic       clk_rise;
    logic       wr_acc;
    logic       mapped;
    logic [7:0] ofs;
    logic [NME_ADDR_MSB:NME_ADDR_LSB] pin_in;

    assign pin_in = external_address_bus_i;
    assign ofs    = paddr;
    assign mapped = (ofs == NME_OFS_CTRL) || (ofs == NME_OFS_ADDR) ||
                    (ofs == NME_OFS_STATUS) || (ofs == NME_OFS_STRAP);
    assign wr_acc = psel && penable && pwrite && mapped;

    // reserved narrow selection falls back to the external clock
    always_comb begin
        case (s_q.strap.narrow_clock_strap)
            NME_CLK_EXT:  cur_clk = s_q.ext_s;
            NME_CLK_DIV4: cur_clk = s_q.clk4;
            NME_CLK_DIV6: cur_clk = s_q.clk6;
            default:      cur_clk = s_q.ext_s;
        endcase
    end
    assign clk_rise = cur_clk && !s_q.sel_clk;

    always_comb begin
        s_d = s_q;

        // straps sampled on the first edge after reset release
        if (!s_q.captured) begin
            s_d.captured = 1'b1;
            s_d.strap.little_endian = pin_in[NME_STRAP_ENDIAN];
            s_d.strap.boot_mode = nme_boot_type'(
                pin_in[NME_STRAP_BOOT_LSB+1:NME_STRAP_BOOT_LSB]);
            s_d.strap.narrow_clock_strap = nme_clk_src_type'(
                pin_in[NME_STRAP_NARR_LSB+1:NME_STRAP_NARR_LSB]);
            s_d.strap.wide_clock_strap = nme_clk_src_type'(
                pin_in[NME_STRAP_WIDE_LSB+1:NME_STRAP_WIDE_LSB]);
            s_d.strap.eeprom_auto_init_strap =
                pin_in[NME_STRAP_EEPROM_AUTO_INIT_STRAP];
            s_d.strap.cell_port_enable_strap =
                pin_in[NME_STRAP_CELL];
        end

        // processor clock derived sources
        s_d.ext_s = ext_input_clock;
        if (s_q.cnt4 == NME_HALF_DIV4) begin
            s_d.cnt4 = 2'h0;
            s_d.clk4 = ~s_q.clk4;
        end else begin
            s_d.cnt4 = s_q.cnt4 + 2'h1;
        end
        if (s_q.cnt6 == NME_HALF_DIV6) begin
            s_d.cnt6 = 2'h0;
            s_d.clk6 = ~s_q.clk6;
        end else begin
            s_d.cnt6 = s_q.cnt6 + 2'h1;
        end
        s_d.sel_clk = cur_clk;

        // register writes
        if (wr_acc && ofs == NME_OFS_CTRL) begin
            s_d.div    = nme_div_type'(
                pwdata[NME_CTRL_DIV_LSB+1:NME_CTRL_DIV_LSB]);
            if (s_q.state == NME_ST_IDLE) begin
                s_d.mtype  = nme_mem_type'(
                    pwdata[NME_CTRL_MTYPE_LSB+1:NME_CTRL_MTYPE_LSB]);
                s_d.rensel = pwdata[NME_CTRL_RENSEL];
                s_d.space  = pwdata[NME_CTRL_SPACE_LSB+1:NME_CTRL_SPACE_LSB];
                s_d.wr     = pwdata[NME_CTRL_WRITE];
            end
        end
        if (wr_acc && ofs == NME_OFS_ADDR && s_q.state == NME_ST_IDLE) begin
            s_d.addr = pwdata[NME_ADDR_W-1:0];
        end
        if (wr_acc && ofs == NME_OFS_STATUS && pwdata[NME_STAT_DONE]) begin
            s_d.done = 1'b0;
        end

        // access sequencer, leaving idle on a start write, then advancing on selected clock rising edges
        case (s_q.state)
            NME_ST_IDLE: begin
                if (wr_acc && ofs == NME_OFS_CTRL &&
                        pwdata[NME_CTRL_START]) begin
                    s_d.state = NME_ST_SETUP;
                end
            end
            NME_ST_SETUP: begin
                if (clk_rise) begin
                    s_d.state = NME_ST_STROBE;
                end
            end
            NME_ST_STROBE: begin
                if (clk_rise && (s_q.mtype != NME_MEM_ASYNC ||
                        async_ready_in)) begin
                    s_d.state = NME_ST_HOLD;
                end
            end
            NME_ST_HOLD: begin
                if (clk_rise) begin
                    s_d.state = NME_ST_IDLE;
                    s_d.done  = 1'b1;
                end
            end
            default: begin
                s_d.state = NME_ST_IDLE;
            end
        endcase

        // pin meaning follows the memory type of the access
        s_d.pins = NME_STROBE_IDLE;
        case (s_d.mtype)
            NME_MEM_ASYNC: begin
                if (s_d.state == NME_ST_STROBE) begin
                    s_d.pins.read_strobe_n   = s_d.wr;
                    s_d.pins.output_enable_n = s_d.wr;
                    s_d.pins.write_strobe_n  = !s_d.wr;
                end
            end
            NME_MEM_SDRAM: begin
                // row strobe on activate, column strobe on the command
                if (s_d.state == NME_ST_SETUP) begin
                    s_d.pins.output_enable_n = 1'b0;
                end
                if (s_d.state == NME_ST_STROBE) begin
                    s_d.pins.read_strobe_n  = 1'b0;
                    s_d.pins.write_strobe_n = !s_d.wr;
                end
            end
            NME_MEM_SYNC: begin
                if (s_d.state == NME_ST_STROBE) begin
                    s_d.pins.read_strobe_n = s_d.rensel ?
                        s_d.wr : 1'b0;
                    s_d.pins.output_enable_n = s_d.wr;
                    s_d.pins.write_strobe_n  = !s_d.wr;
                    s_d.pins.fifo_oe_n = s_d.wr ||
                        (s_d.space != NME_SPACE_FIFO);
                end
            end
            default: begin
                s_d.pins = NME_STROBE_IDLE;
            end
        endcase

        // read data captured in the setup phase
        if (psel && !penable) begin
            s_d.rdata = '0;
            case (ofs)
                NME_OFS_CTRL: begin
                    s_d.rdata[NME_CTRL_DIV_LSB+1:NME_CTRL_DIV_LSB] = s_q.div;
                    s_d.rdata[NME_CTRL_MTYPE_LSB+1:NME_CTRL_MTYPE_LSB] =
                        s_q.mtype;
                    s_d.rdata[NME_CTRL_RENSEL] = s_q.rensel;
                    s_d.rdata[NME_CTRL_SPACE_LSB+1:NME_CTRL_SPACE_LSB] =
                        s_q.space;
                    s_d.rdata[NME_CTRL_WRITE] = s_q.wr;
                end
                NME_OFS_ADDR: begin
                    s_d.rdata[NME_ADDR_W-1:0] = s_q.addr;
                end
                NME_OFS_STATUS: begin
                    s_d.rdata[NME_STAT_BUSY] = (s_q.state != NME_ST_IDLE);
                    s_d.rdata[NME_STAT_DONE] = s_q.done;
                    s_d.rdata[NME_STAT_CLK_RSVD] =
                        (s_q.strap.narrow_clock_strap == NME_CLK_RSVD);
                end
                NME_OFS_STRAP: begin
                    s_d.rdata[NME_SR_ENDIAN] = s_q.strap.little_endian;
                    s_d.rdata[NME_SR_BOOT_LSB+1:NME_SR_BOOT_LSB] =
                        s_q.strap.boot_mode;
                    s_d.rdata[NME_SR_NARR_LSB+1:NME_SR_NARR_LSB] =
                        s_q.strap.narrow_clock_strap;
                    s_d.rdata[NME_SR_WIDE_LSB+1:NME_SR_WIDE_LSB] =
                        s_q.strap.wide_clock_strap;
                    s_d.rdata[NME_SR_EEPROM_AUTO_INIT_STRAP] =
                        s_q.strap.eeprom_auto_init_strap;
                    s_d.rdata[NME_SR_CELL] =
                        s_q.strap.cell_port_enable_strap;
                end
                default: begin
                    s_d.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q          <= '0;
            s_q.strap    <= NME_STRAP_RESET;
            s_q.pins     <= NME_STROBE_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    nme_clk_div u_div (
        .pclk      (pclk),
        .presetn   (presetn),
        .src_level (cur_clk),
        .src_rise  (clk_rise),
        .div_sel   (s_q.div),
        .div_clk   (divided_output_clock)
    );

    assign prdata  = s_q.rdata;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // pins stay inputs until the straps have been taken
    assign external_address_bus_o  = s_q.addr;
    assign external_address_bus_oe = {NME_ADDR_W{s_q.captured}};

    assign full_rate_output_clock = s_q.sel_clk;
    assign strobe_pins            = s_q.pins;
    assign straps                 = s_q.strap;
    assign cell_port_en           = s_q.strap.cell_port_enable_strap;
    assign serial_port_one_en     = !s_q.strap.cell_port_enable_strap;
    assign eeprom_auto_init_en    = s_q.strap.eeprom_auto_init_strap;
    assign wide_clock_sel         = s_q.strap.wide_clock_strap;

endmodule

`default_nettype wire

// File: testbench/nme_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module nme_mem_model
    import nme_pkg::*;
(
    input  wire logic                  pclk,
    input  wire logic [NME_ADDR_W-1:0] strap_val,
    input  wire logic [3:0]            ready_wait,
    input  wire logic [NME_ADDR_W-1:0] external_address_bus_o,
    input  wire logic [NME_ADDR_W-1:0] external_address_bus_oe,
    input  wire nme_strobe_type        strobe_pins,
    output logic [NME_ADDR_W-1:0]      external_address_bus_i,
    output logic                       async_ready_in,
    output logic                       ext_input_clock
);
    logic [2:0] ck_cnt;
    logic [4:0] wait_cnt;

    initial begin
        ext_input_clock = 1'b0;
        async_ready_in = 1'b0;
        ck_cnt = '0;
        wait_cnt = '0;
    end

    // board pulls show wherever the device releases a pin
    assign external_address_bus_i =
        (external_address_bus_oe & external_address_bus_o)
        | (~external_address_bus_oe & strap_val);

    // free running board clock, ten pclk periods
    always @(posedge pclk) begin
        ck_cnt <= (ck_cnt == 3'h4) ? 3'h0 : ck_cnt + 3'h1;
        if (ck_cnt == 3'h4)
            ext_input_clock <= ~ext_input_clock;
    end

    // slow memory holds ready low for a programmable time
    always @(posedge pclk) begin
        if (strobe_pins.read_strobe_n && strobe_pins.write_strobe_n) begin
            wait_cnt <= '0;
            async_ready_in <= 1'b0;
        end else begin
            wait_cnt <= wait_cnt + 5'h1;
            async_ready_in <= (wait_cnt >= {1'b0, ready_wait});
        end
    end
endmodule

`default_nettype wire

// File: testbench/nme_strap_pins_checker.sv
`timescale 1ns/1ps
`default_nettype none

module nme_strap_pins_checker
    import nme_pkg::*;
(
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic                  pready,
    input wire logic [7:0]            paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [NME_ADDR_W-1:0] external_address_bus_i,
    input wire logic [NME_ADDR_W-1:0] external_address_bus_o,
    input wire logic [NME_ADDR_W-1:0] external_address_bus_oe,
    input wire logic                  full_rate_output_clock,
    input wire nme_strobe_type        strobe_pins,
    input wire nme_strap_type         straps,
    input wire logic                  serial_port_one_en,
    input wire logic                  cell_port_en,
    input wire logic                  eeprom_auto_init_en,
    input wire nme_clk_src_type       wide_clock_sel
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [NME_ADDR_W-1:0] addr_q;
    logic [NME_ADDR_W-1:0] b;
    nme_strap_type         pin_straps;

    // pin n of the bus sits at bit n-1
    assign b = external_address_bus_i;
    assign pin_straps = nme_strap_type'({b[19], b[18:17], b[14:13],
                                         b[16:15], b[12], b[10]});

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            addr_q <= '0;
        else if (psel && penable && pready && pwrite
                 && paddr == NME_OFS_ADDR)
            addr_q <= pwdata[NME_ADDR_W-1:0];
    end

    a_oe_after_reset: assert property (
        $rose(presetn) |-> external_address_bus_oe == '0
        ##1 external_address_bus_oe == '1)
        else $error("address pins turned around at wrong edge");
    a_strobe_idle: assert property (
        $rose(presetn) |-> strobe_pins == NME_STROBE_IDLE)
        else $error("strobes active right after reset");
    a_straps_latched: assert property (
        $rose(presetn) |=> straps == $past(pin_straps))
        else $error("straps differ from pin levels at release");
    a_straps_hold: assert property (
        $past(presetn, 2) |-> $stable(straps))
        else $error("straps changed after latching");
    a_strap_outputs: assert property (
        serial_port_one_en == !straps.cell_port_enable_strap
        && cell_port_en == straps.cell_port_enable_strap
        && eeprom_auto_init_en == straps.eeprom_auto_init_strap
        && wide_clock_sel == straps.wide_clock_strap)
        else $error("enable outputs disagree with straps");
    a_addr_halfword: assert property (
        external_address_bus_oe == '1 |-> external_address_bus_o == addr_q)
        else $error("address pins differ from written address");
    a_fifo_oe_read: assert property (
        !strobe_pins.fifo_oe_n |->
        !strobe_pins.output_enable_n && strobe_pins.write_strobe_n)
        else $error("fifo enable outside a read");
    a_cpu4_rate: assert property (
        $past(straps.narrow_clock_strap) == NME_CLK_DIV4
        && $rose(full_rate_output_clock) |->
        ##2 $fell(full_rate_output_clock) ##2 $rose(full_rate_output_clock))
        else $error("cpu/4 clock has wrong shape");
    a_cpu6_rate: assert property (
        $past(straps.narrow_clock_strap) == NME_CLK_DIV6
        && $rose(full_rate_output_clock) |->
        ##3 $fell(full_rate_output_clock) ##3 $rose(full_rate_output_clock))
        else $error("cpu/6 clock has wrong shape");
endmodule

`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] %s exp %0h got %0h", n, e, g); end end

module tb
    import nme_pkg::*;
;
    logic                  pclk = 1'b0;
    logic                  presetn = 1'b0;
    logic                  psel = 1'b0;
    logic                  penable = 1'b0;
    logic                  pwrite = 1'b0;
    logic [7:0]            paddr = '0;
    logic [31:0]           pwdata = '0;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  ext_input_clock;
    logic                  async_ready_in;
    logic [NME_ADDR_W-1:0] bus_i;
    logic [NME_ADDR_W-1:0] bus_o;
    logic [NME_ADDR_W-1:0] bus_oe;
    logic                  full_clk;
    logic                  div_clk;
    nme_strobe_type        strobe_pins;
    nme_strap_type         straps;
    logic                  spo_en;
    logic                  cell_en;
    logic                  eeprom_auto_init_strap_en;
    nme_clk_src_type       wide_sel;
    logic [NME_ADDR_W-1:0] strap_val = '0;
    logic [3:0]            ready_wait = '0;
    logic                  mon = 1'b0;
    logic [3:0]            lows = '0;
    int                    low_cnt = 0;
    int                    failures = 0;
    int                    compares = 0;
    logic [31:0]           rd_q;
    logic                  err_q;
    logic [1:0]            c;
    int                    n;
    int                    full_exp[4] = '{12, 30, 20, 12};
    int                    div_exp[4] = '{12, 6, 3, 12};
    logic [8:0]            acc_ctrl[9] = '{9'h100, 9'h180, 9'h104, 9'h184,
                               9'h168, 9'h1E8, 9'h118, 9'h198, 9'h100};
    logic [3:0]            acc_mask[9] = '{4'hC, 4'h2, 4'hC, 4'hE,
                               4'hD, 4'hA, 4'hC, 4'h2, 4'hC};

    always #5 pclk = ~pclk;

    nme_strap_pins i_nme_strap_pins (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_input_clock(ext_input_clock),
        .async_ready_in(async_ready_in), .external_address_bus_i(bus_i),
        .external_address_bus_o(bus_o), .external_address_bus_oe(bus_oe),
        .full_rate_output_clock(full_clk), .divided_output_clock(div_clk),
        .strobe_pins(strobe_pins), .straps(straps),
        .serial_port_one_en(spo_en), .cell_port_en(cell_en),
        .eeprom_auto_init_en(eeprom_auto_init_strap_en), .wide_clock_sel(wide_sel));

    nme_mem_model i_nme_mem_model (.pclk(pclk), .strap_val(strap_val),
        .ready_wait(ready_wait), .external_address_bus_o(bus_o),
        .external_address_bus_oe(bus_oe), .strobe_pins(strobe_pins),
        .external_address_bus_i(bus_i), .async_ready_in(async_ready_in),
        .ext_input_clock(ext_input_clock));

    always @(posedge pclk) begin
        lows <= mon ? lows | ~strobe_pins : 4'h0;
        low_cnt <= mon ? low_cnt + int'(!strobe_pins.read_strobe_n) : 0;
    end

    task automatic give_verdict();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            failures++;
            give_verdict();
        end
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rst(input logic [NME_ADDR_W-1:0] s);
        presetn <= 1'b0;
        strap_val <= s;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask

    // window spans whole periods
    task automatic rises(input logic dv, output int r);
        logic prv;
        logic cur;
        r = 0;
        prv = dv ? div_clk : full_clk;
        repeat (120) begin
            @(posedge pclk);
            cur = dv ? div_clk : full_clk;
            if (cur === 1'b1 && prv === 1'b0)
                r++;
            prv = cur;
        end
    endtask

    initial begin
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            rst({c[0], c, ~c, c, c[1], 1'b0, ~c[0], 10'h0});
            apb(NME_OFS_STRAP, 1'b0, '0);
            `CHK("strap reg", {23'h0, ~c[0], c[1], ~c, c, c, c[0]}, rd_q)
            `CHK("enables", {c[0], ~c[0], c[1], ~c}, {spo_en, cell_en, eeprom_auto_init_strap_en, wide_sel})
            rises(1'b0, n);
            `CHK("full clock", full_exp[i], n)
            apb(NME_OFS_STATUS, 1'b0, '0);
            `CHK("reserved flag", c == 2'h3, rd_q[NME_STAT_CLK_RSVD])
            $display("strap test %0d done", i);
        end
        rst({1'b1, 2'h2, 17'h0});
        `CHK("default straps", NME_STRAP_RESET, straps)
        for (int d = 0; d < 4; d++) begin
            apb(NME_OFS_CTRL, 1'b1, 32'(d));
            repeat (50) @(posedge pclk);
            rises(1'b1, n);
            `CHK("divided clock", div_exp[d], n)
        end
        $display("divider test done");
        for (int k = 0; k < 9; k++) begin
            ready_wait <= (k == 8) ? 4'hF : 4'h0;
            apb(NME_OFS_ADDR, 1'b1, 32'h000ABCD0 + 32'(k));
            mon <= 1'b1;
            apb(NME_OFS_CTRL, 1'b1, {23'h0, acc_ctrl[k]});
            `CHK("address pins", 20'hABCD0 + 20'(k), bus_o)
            n = 0;
            do begin
                apb(NME_OFS_STATUS, 1'b0, '0);
                n++;
            end while (rd_q[NME_STAT_DONE] !== 1'b1 && n < 100);
            if (n >= 100) begin
                failures++;
                give_verdict();
            end
            mon <= 1'b0;
            `CHK("strobes seen low", acc_mask[k], lows)
            if (k == 8)
                `CHK("ready wait", 1'b1, low_cnt > 15)
            apb(NME_OFS_STATUS, 1'b1, 32'h2);
            apb(NME_OFS_STATUS, 1'b0, '0);
            `CHK("status idle", 2'h0, rd_q[1:0])
            $display("access test %0d done", k);
        end
        apb(8'h10, 1'b0, '0);
        `CHK("unmapped", 33'h100000000, {err_q, rd_q})
        give_verdict();
    end
endmodule

bind nme_strap_pins nme_strap_pins_checker i_chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .paddr(paddr), .pwdata(pwdata),
    .external_address_bus_i(external_address_bus_i),
    .external_address_bus_o(external_address_bus_o),
    .external_address_bus_oe(external_address_bus_oe),
    .full_rate_output_clock(full_rate_output_clock),
    .strobe_pins(strobe_pins), .straps(straps),
    .serial_port_one_en(serial_port_one_en), .cell_port_en(cell_port_en),
    .eeprom_auto_init_en(eeprom_auto_init_en),
    .wide_clock_sel(wide_clock_sel));

`default_nettype wire
